/* File: rssp_master.sv */
/*
 * two-wire bus master that reaches the clock/calendar slave port: pointer
 * writes, data writes, pointer-set reads and alternate reads.
 * assumes open-drain pads with pull-ups outside; pin inputs are asynchronous.
 */
`timescale 1ns/100ps
module rssp_master
   import rssp_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // command
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       cmd_read,
   input  wire logic       cmd_set_ptr,
   input  wire logic [7:0] cmd_word,
   input  wire logic [7:0] cmd_len,
   // write data stream
   input  wire logic       wr_valid,
   output logic            wr_ready,
   input  wire logic [7:0] wr_data,
   // read data stream
   output logic            rd_valid,
   input  wire logic       rd_ready,
   output logic [7:0]      rd_data,
   // status
   output logic            busy,
   output logic            done,
   output logic            nack_err,
   // bus pins, open drain
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe
);

   rssp_state_t state_reg, state_next;
   rssp_phase_t phase_reg, phase_next;
   logic [10:0] tmr_reg, tmr_next;
   logic [3:0]  bit_reg, bit_next;
   logic [7:0]  sh_reg, sh_next;
   logic [7:0]  cnt_reg, cnt_next;
   logic [7:0]  word_reg, word_next;
   logic        rdcmd_reg, rdcmd_next;
   logic        scl_oe_reg, scl_oe_next;
   logic        sda_oe_reg, sda_oe_next;
   logic        wr_ready_reg, wr_ready_next;
   logic        nack_reg, nack_next;
   logic        done_reg, done_next;
   logic        busy_reg, cmd_ready_reg, drv_lvl_reg;
   logic [1:0]  scl_sync_reg, sda_sync_reg;
   logic        out_v_reg, sk_v_reg;
   logic [7:0]  out_d_reg, sk_d_reg;
   logic        rx_push;

   wire scl_s    = scl_sync_reg[1];
   wire sda_s    = sda_sync_reg[1];
   wire bus_idle = scl_s & sda_s;
   wire in_high  = (state_reg == ST_HIGH) || (state_reg == ST_RS_HIGH) ||
                   (state_reg == ST_STOP_HIGH);
   // a slave stretching scl low freezes the high-phase timer
   wire tmr_run  = (tmr_reg != 11'h000) && !(in_high && !scl_s);
   wire tdone    = (tmr_reg == 11'h000) && (!in_high || scl_s);
   wire at_half  = (tmr_reg == C_LOW_HALF);
   wire is_rd    = (phase_reg == PH_RDATA);
   wire last_rd  = (cnt_reg <= 8'h01);
   wire ack_drv  = is_rd && !last_rd;
   wire bit_drv  = bit_reg[3] ? ack_drv : (!is_rd && !sh_reg[7]);
   wire ack_ok   = !sda_s;
   wire buf_full = out_v_reg & sk_v_reg;
   wire pop      = rd_ready & out_v_reg;

   assign cmd_ready = cmd_ready_reg;
   assign wr_ready  = wr_ready_reg;
   assign rd_valid  = out_v_reg;
   assign rd_data   = out_d_reg;
   assign busy      = busy_reg;
   assign done      = done_reg;
   assign nack_err  = nack_reg;
   assign scl_out   = drv_lvl_reg;
   assign sda_out   = drv_lvl_reg;
   assign scl_oe    = scl_oe_reg;
   assign sda_oe    = sda_oe_reg;

   always_comb begin
      state_next    = state_reg;
      phase_next    = phase_reg;
      tmr_next      = tmr_run ? tmr_reg - 11'h001 : tmr_reg;
      bit_next      = bit_reg;
      sh_next       = sh_reg;
      cnt_next      = cnt_reg;
      word_next     = word_reg;
      rdcmd_next    = rdcmd_reg;
      scl_oe_next   = scl_oe_reg;
      sda_oe_next   = sda_oe_reg;
      wr_ready_next = 1'b0;
      nack_next     = nack_reg;
      done_next     = 1'b0;
      rx_push       = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            scl_oe_next = 1'b0;
            sda_oe_next = 1'b0;
            if (cmd_valid && cmd_ready_reg) begin
               nack_next   = 1'b0;
               rdcmd_next  = cmd_read;
               cnt_next    = cmd_len;
               word_next   = cmd_word;
               if (cmd_read && !cmd_set_ptr) begin
                  phase_next = PH_ADDR_R;
                  sh_next    = {SLAVE_ADDR, DIR_READ};
               end else begin
                  phase_next = PH_ADDR_W;
                  sh_next    = {SLAVE_ADDR, DIR_WRITE};
               end
               sda_oe_next = 1'b1;
               tmr_next    = C_HD_STA;
               state_next  = ST_START;
            end
         end
         ST_START: begin
            if (tdone) begin
               scl_oe_next = 1'b1;
               bit_next    = 4'h0;
               tmr_next    = C_LOW;
               state_next  = ST_LOW;
            end
         end
         ST_LOW: begin
            if (at_half) begin
               sda_oe_next = bit_drv;
            end
            if (tdone) begin
               scl_oe_next = 1'b0;
               tmr_next    = C_HIGH;
               state_next  = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (tdone) begin
               scl_oe_next = 1'b1;
               tmr_next    = C_LOW;
               if (bit_reg != ACK_BIT_IDX) begin
                  sh_next    = {sh_reg[6:0], sda_s};
                  bit_next   = bit_reg + 4'h1;
                  state_next = ST_LOW;
               end else if (!is_rd && !ack_ok) begin
                  nack_next  = 1'b1;
                  state_next = ST_STOP_LOW;
               end else begin
                  bit_next = 4'h0;
                  case (phase_reg)
                     PH_ADDR_W: begin
                        phase_next = PH_WORD;
                        sh_next    = word_reg;
                        state_next = ST_LOW;
                     end
                     PH_WORD: begin
                        if (rdcmd_reg) begin
                           phase_next = PH_ADDR_R;
                           sh_next    = {SLAVE_ADDR, DIR_READ};
                           state_next = ST_RS_LOW;
                        end else if (cnt_reg == 8'h00) begin
                           state_next = ST_STOP_LOW;
                        end else begin
                           phase_next = PH_WDATA;
                           state_next = ST_WAIT;
                        end
                     end
                     PH_WDATA: begin
                        cnt_next   = cnt_reg - 8'h01;
                        state_next = (cnt_reg == 8'h01) ? ST_STOP_LOW : ST_WAIT;
                     end
                     PH_ADDR_R: begin
                        phase_next = PH_RDATA;
                        state_next = ST_WAIT;
                     end
                     default: begin
                        rx_push    = 1'b1;
                        cnt_next   = cnt_reg - 8'h01;
                        state_next = last_rd ? ST_STOP_LOW : ST_WAIT;
                     end
                  endcase
               end
            end
         end
         ST_WAIT: begin
            // scl stays low here, so a stalled stream simply stretches the bus
            tmr_next = C_LOW;
            if (phase_reg == PH_WDATA) begin
               wr_ready_next = !(wr_valid && wr_ready_reg);
               if (wr_valid && wr_ready_reg) begin
                  sh_next    = wr_data;
                  state_next = ST_LOW;
               end
            end else if (!buf_full) begin
               sh_next    = 8'hff;
               state_next = ST_LOW;
            end
         end
         ST_RS_LOW: begin
            if (at_half) begin
               sda_oe_next = 1'b0;
            end
            if (tdone) begin
               scl_oe_next = 1'b0;
               tmr_next    = C_SU_STA;
               state_next  = ST_RS_HIGH;
            end
         end
         ST_RS_HIGH: begin
            if (tdone) begin
               sda_oe_next = 1'b1;
               tmr_next    = C_HD_STA;
               state_next  = ST_START;
            end
         end
         ST_STOP_LOW: begin
            if (at_half) begin
               sda_oe_next = 1'b1;
            end
            if (tdone) begin
               scl_oe_next = 1'b0;
               tmr_next    = C_SU_STO;
               state_next  = ST_STOP_HIGH;
            end
         end
         ST_STOP_HIGH: begin
            if (tdone) begin
               sda_oe_next = 1'b0;
               tmr_next    = C_BUF;
               state_next  = ST_BUF;
            end
         end
         default: begin
            if (tdone) begin
               done_next  = 1'b1;
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= ST_IDLE;
         phase_reg    <= PH_ADDR_W;
         tmr_reg      <= 11'h000;
         bit_reg      <= 4'h0;
         sh_reg       <= 8'h00;
         cnt_reg      <= 8'h00;
         word_reg     <= 8'h00;
         rdcmd_reg    <= 1'b0;
         scl_oe_reg   <= 1'b0;
         sda_oe_reg   <= 1'b0;
         wr_ready_reg <= 1'b0;
         nack_reg     <= 1'b0;
         done_reg     <= 1'b0;
      end else begin
         state_reg    <= state_next;
         phase_reg    <= phase_next;
         tmr_reg      <= tmr_next;
         bit_reg      <= bit_next;
         sh_reg       <= sh_next;
         cnt_reg      <= cnt_next;
         word_reg     <= word_next;
         rdcmd_reg    <= rdcmd_next;
         scl_oe_reg   <= scl_oe_next;
         sda_oe_reg   <= sda_oe_next;
         wr_ready_reg <= wr_ready_next;
         nack_reg     <= nack_next;
         done_reg     <= done_next;
      end
   end

   // status flops and pin synchronisers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         busy_reg      <= 1'b0;
         cmd_ready_reg <= 1'b0;
         drv_lvl_reg   <= 1'b0;
         scl_sync_reg  <= 2'b11;
         sda_sync_reg  <= 2'b11;
      end else begin
         busy_reg      <= (state_next != ST_IDLE);
         cmd_ready_reg <= (state_next == ST_IDLE) && bus_idle && !cmd_valid_taken();
         drv_lvl_reg   <= 1'b0;
         scl_sync_reg  <= {scl_sync_reg[0], scl_in};
         sda_sync_reg  <= {sda_sync_reg[0], sda_in};
      end
   end

   function automatic logic cmd_valid_taken();
      cmd_valid_taken = cmd_valid && cmd_ready_reg;
   endfunction : cmd_valid_taken

   // two-entry read buffer: output stage plus one skid slot
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         out_v_reg <= 1'b0;
         sk_v_reg  <= 1'b0;
         out_d_reg <= 8'h00;
         sk_d_reg  <= 8'h00;
      end else if (!out_v_reg || pop) begin
         out_v_reg <= sk_v_reg | rx_push;
         out_d_reg <= sk_v_reg ? sk_d_reg : sh_reg;
         sk_v_reg  <= sk_v_reg & rx_push;
         sk_d_reg  <= sh_reg;
      end else if (rx_push) begin
         sk_v_reg  <= 1'b1;
         sk_d_reg  <= sh_reg;
      end
   end

endmodule : rssp_master

/* File: rssp_pkg.sv */
/*
 * constants, states and bus phases shared by the two-wire master that drives
 * the clock/calendar slave port.
 * assumes a 250 MHz core clock and a 100 kHz standard-mode bus.
 */
package rssp_pkg;

   // bus addressing
   localparam logic [6:0] SLAVE_ADDR   = 7'h68;  // d0h with the direction bit cleared
   localparam logic       DIR_WRITE    = 1'b0;
   localparam logic       DIR_READ     = 1'b1;
   localparam logic [3:0] ACK_BIT_IDX  = 4'h8;

   // bus timing, in ns as printed, and derived cycle counts (rounded up)
   localparam int CLK_PERIOD_NS = 4;
   localparam int T_LOW_NS      = 4700;
   localparam int T_HIGH_NS     = 4000;
   localparam int T_HD_STA_NS   = 4000;
   localparam int T_SU_STA_NS   = 4700;
   localparam int T_SU_STO_NS   = 4700;
   localparam int T_BUF_NS      = 4700;

   localparam logic [10:0] C_LOW      = 11'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] C_HIGH     = 11'((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] C_HD_STA   = 11'((T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] C_SU_STA   = 11'((T_SU_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] C_SU_STO   = 11'((T_SU_STO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] C_BUF      = 11'((T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // sda moves halfway through the low phase, far from both scl edges
   localparam logic [10:0] C_LOW_HALF = C_LOW >> 1;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_START     = 4'h1,
      ST_LOW       = 4'h2,
      ST_HIGH      = 4'h3,
      ST_WAIT      = 4'h4,
      ST_RS_LOW    = 4'h5,
      ST_RS_HIGH   = 4'h6,
      ST_STOP_LOW  = 4'h7,
      ST_STOP_HIGH = 4'h8,
      ST_BUF       = 4'h9
   } rssp_state_t;

   typedef enum logic [2:0] {
      PH_ADDR_W = 3'h0,
      PH_WORD   = 3'h1,
      PH_WDATA  = 3'h2,
      PH_ADDR_R = 3'h3,
      PH_RDATA  = 3'h4
   } rssp_phase_t;

endpackage : rssp_pkg

/* File: rssp_slave_model.sv */
/* behavioural clock/calendar slave on the two-wire bus, eight bytes.
   assumes wire levels with pull-ups, worked out by the bench. */
`timescale 1ns/100ps
module rssp_slave_model (
   // bus wires
   input  wire logic scl,
   input  wire logic sda,
   // supply above switchover_threshold
   input  wire logic supply_ok,
   // pulls sda low
   output logic      sda_oe
);
   localparam logic [6:0] OWN_ADDR = 7'h68;
   logic [7:0] mem [8];
   logic [7:0] sh;
   logic [2:0] ptr = 3'h0;
   int         bn = 0;
   logic       act = 1'b0;
   logic       rd = 1'b0;
   logic       first = 1'b0;
   logic       wrd = 1'b0;
   initial begin
      sda_oe = 1'b0;
      for (int i = 0; i < 8; i++) mem[i] = 8'h30 + 8'(i);
   end
   always @(negedge sda) if (scl && supply_ok) begin
      act = 1'b1;
      first = 1'b1;
      bn = 0;
      rd = 1'b0;
   end
   always @(posedge sda) if (scl) act = 1'b0;
   always @(negedge supply_ok) begin
      act = 1'b0;
      ptr = 3'h0;
      sda_oe = 1'b0;
   end
   // own address ack (sda_oe still high) is not a master ack of a data byte
   always @(posedge scl) if (act) begin
      if (bn < 8) sh = {sh[6:0], sda};
      else if (rd && !sda_oe && !sda) ptr = ptr + 3'h1;
      else if (rd && !sda_oe) act = 1'b0;
      bn = (bn == 8) ? 0 : bn + 1;
   end
   always @(negedge scl) if (act) begin
      sda_oe = 1'b0;
      if (bn == 8 && first) begin
         act = (sh[7:1] == OWN_ADDR);
         rd = sh[0];
         wrd = !sh[0];
         first = 1'b0;
         sda_oe = act;
      end else if (bn == 8 && !rd) begin
         if (wrd) ptr = sh[2:0];
         else mem[ptr] = sh;
         if (!wrd) ptr = ptr + 3'h1;
         wrd = 1'b0;
         sda_oe = 1'b1;
      end else if (rd && bn < 8) sda_oe = !mem[ptr][7-bn];
   end
endmodule : rssp_slave_model

/* File: rssp_master_assertions.sv */
/* concurrent checks on the two-wire master's ports.
   assumes the single mclk domain with rst_b active low. */
`timescale 1ns/100ps
module rssp_master_assertions (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst_b,
   // command and read stream
   input wire logic       cmd_valid,
   input wire logic       cmd_ready,
   input wire logic       rd_valid,
   input wire logic       rd_ready,
   input wire logic [7:0] rd_data,
   // status
   input wire logic       busy,
   input wire logic       done,
   input wire logic       nack_err,
   // pin enables
   input wire logic       scl_oe,
   input wire logic       sda_oe
);
   logic [11:0] hi_cnt;
   logic [11:0] lo_cnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // saturating, so a long stall cannot wrap under the limit
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hi_cnt <= 12'h000;
         lo_cnt <= 12'h000;
      end else begin
         hi_cnt <= (scl_oe || !busy) ? 12'h000 : hi_cnt + {11'h000, hi_cnt != 12'hfff};
         lo_cnt <= !scl_oe ? 12'h000 : lo_cnt + {11'h000, lo_cnt != 12'hfff};
      end
   end
   sequence scl_quiet;
      $stable(scl_oe) [*8];
   endsequence
   sequence bus_free;
      (!scl_oe && !sda_oe) [*8];
   endsequence
   take_start_a: assert property (cmd_valid && cmd_ready |=> busy && sda_oe && !scl_oe)
      else $error("no start after command take");
   ready_idle_a: assert property (cmd_ready |-> !busy && !scl_oe && !sda_oe)
      else $error("ready while bus not idle");
   scl_high_a: assert property ($rose(scl_oe) |-> hi_cnt >= 12'h3e6)
      else $error("clock high too short");
   scl_low_a: assert property ($fell(scl_oe) && busy |-> lo_cnt >= 12'h496)
      else $error("clock low too short");
   sda_setup_a: assert property ($changed(sda_oe) |-> $stable(scl_oe) ##1 scl_quiet)
      else $error("data moved next to a clock edge");
   stop_free_a: assert property ($fell(sda_oe) && !scl_oe |-> bus_free)
      else $error("bus not idle after stop");
   // a new command may be taken in the done cycle itself, so busy follows that take
   done_end_a: assert property (done |-> !scl_oe && !sda_oe && !busy
      ##1 !done && (busy == ($past(cmd_valid) && $past(cmd_ready))))
      else $error("done not a single pulse on idle bus");
   nack_seen_a: assert property ($rose(nack_err) |-> busy && !$past(scl_oe))
      else $error("nack flagged outside a clock high");
   rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read byte lost while stalled");
endmodule : rssp_master_assertions

bind rssp_master rssp_master_assertions u_chk (
   .mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy),
   .done(done), .nack_err(nack_err), .scl_oe(scl_oe), .sda_oe(sda_oe));

/* File: rssp_master_bench.sv */
/* self-checking bench: master against the slave model.
   assumes pulled-up wires; inputs move on the falling edge. */
`timescale 1ns/100ps
module rssp_master_bench;
   import rssp_pkg::*;
   logic       mclk = 1'b0;
   logic       rst_b = 1'b0;
   logic       cmd_valid = 1'b0;
   logic       cmd_read = 1'b0;
   logic       cmd_set_ptr = 1'b0;
   logic       wr_valid = 1'b0;
   logic       rd_ready = 1'b0;
   logic       supply_ok = 1'b1;
   logic [7:0] cmd_word = 8'h00;
   logic [7:0] cmd_len = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] rd_data;
   logic [7:0] addr_seen;
   logic       cmd_ready, wr_ready, rd_valid, busy, done, nack_err;
   logic       scl_oe, sda_oe, s_oe;
   int         n_mismatch = 0;
   int         n_checks = 0;
   int         bits = 0;
   wire        scl = !scl_oe;
   wire        sda = !(sda_oe || s_oe);
   always #2 mclk = ~mclk;
   rssp_master dut (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_set_ptr(cmd_set_ptr),
      .cmd_word(cmd_word), .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
      .busy(busy), .done(done), .nack_err(nack_err), .scl_in(scl), .scl_out(),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
   rssp_slave_model slave (.scl(scl), .sda(sda), .supply_ok(supply_ok), .sda_oe(s_oe));
   // first byte seen on the wire after each start
   always @(negedge sda) if (scl) bits = 0;
   always @(posedge scl) begin
      if (bits < 8) addr_seen = {addr_seen[6:0], sda};
      bits++;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic wait_hi(input logic on_done, input int lim);
      int i;
      i = 0;
      while ((on_done ? done : cmd_ready) !== 1'b1 && i < lim) begin
         @(negedge mclk);
         i++;
      end
      if (i >= lim) begin
         chk(1'b0, "wait ran out");
         wrap_up();
      end
   endtask : wait_hi
   task automatic run_cmd(input logic rd, input logic sp, input logic [7:0] word,
                          input logic [7:0] len);
      wait_hi(1'b0, 5000);
      cmd_read = rd;
      cmd_set_ptr = sp;
      cmd_word = word;
      cmd_len = len;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      wait_hi(1'b1, 150000);
      chk(scl === 1'b1 && sda === 1'b1, "bus not idle after done");
   endtask : run_cmd
   task automatic write_case();
      wr_data = 8'h5a;
      wr_valid = 1'b1;
      run_cmd(1'b0, 1'b0, 8'h06, 8'h01);
      wr_valid = 1'b0;
      chk(addr_seen === 8'hd0, "write address byte");
      chk(slave.mem[6] === 8'h5a, "data byte not stored");
      chk(slave.ptr === 3'h7, "pointer after write");
      chk(nack_err === 1'b0, "write refused");
   endtask : write_case
   task automatic read_case();
      run_cmd(1'b1, 1'b0, 8'h00, 8'h01);
      chk(addr_seen === 8'hd1, "read address byte");
      // model presets every byte to 8'h30 plus its index; index 7 is the control byte
      chk(rd_valid === 1'b1 && rd_data === 8'h37, "read byte");
      chk(slave.ptr === 3'h7, "pointer moved on final byte");
      rd_ready = 1'b1;
      @(negedge mclk);
      rd_ready = 1'b0;
      chk(rd_valid === 1'b0, "buffer not drained");
   endtask : read_case
   task automatic supply_case();
      supply_ok = 1'b0;
      @(negedge mclk);
      chk(slave.ptr === 3'h0, "pointer not cleared");
      run_cmd(1'b1, 1'b0, 8'h00, 8'h01);
      chk(nack_err === 1'b1, "address acked while supply low");
      chk(rd_valid === 1'b0, "byte read while supply low");
      supply_ok = 1'b1;
   endtask : supply_case
   // pointer-set read of two bytes once the supply is back: repeated start, master ack
   task automatic ptr_read_case();
      run_cmd(1'b1, 1'b1, 8'h06, 8'h02);
      chk(nack_err === 1'b0, "refused after supply returned");
      chk(addr_seen === 8'hd1, "address after repeated start");
      chk(rd_valid === 1'b1 && rd_data === 8'h5a, "first pointer read byte");
      chk(slave.ptr === 3'h7, "pointer after acked byte");
      rd_ready = 1'b1;
      @(negedge mclk);
      chk(rd_valid === 1'b1 && rd_data === 8'h37, "second buffered byte");
      @(negedge mclk);
      rd_ready = 1'b0;
      chk(rd_valid === 1'b0, "buffer not drained after two pops");
   endtask : ptr_read_case
   initial begin
      repeat (20) @(negedge mclk);
      rst_b = 1'b1;
      write_case();
      read_case();
      supply_case();
      ptr_read_case();
      wrap_up();
   end
endmodule : rssp_master_bench
